// File: shared/timer_pkg.sv
package timer_pkg;

  localparam int          CNT_W      = 8;
  localparam logic [7:0]  CNT_MAX    = 8'hFF;
  localparam logic [7:0]  CNT_ZERO   = 8'h00;
  localparam logic [7:0]  PRESET_RST = 8'h00;
  localparam int          DIV_A_SLOW = 64;
  localparam int          DIV_A_FAST = 8;
  localparam int          DIV_B_DEF  = 65536;
  localparam int          PRE_W      = 32;

  typedef enum logic [1:0] {
    SRC_A_CPU,
    SRC_A_DIV8,
    SRC_A_DIV64,
    SRC_A_CASCADE
  } a_src_t;

  typedef enum logic [2:0] {
    SRC_B_CPU,
    SRC_B_DIV,
    SRC_B_EXT,
    SRC_B_LOW,
    SRC_B_HIGH
  } b_src_t;

  typedef enum logic {
    MODE_TIMER,
    MODE_COUNTER
  } b_mode_t;

  typedef struct packed {
    logic [7:0] count;
    logic       ovf;
    logic       irq;
  } unit_out_t;

endpackage

// File: logic/dual_reload_timer_counter.sv
`timescale 1ns/1ps
module dual_reload_timer_counter #(
  parameter int B_DIV = timer_pkg::DIV_B_DEF
) (
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 A_WR,
  input  wire logic [7:0]           A_WDATA,
  input  wire timer_pkg::a_src_t    A_SRC,
  input  wire logic                 A_IRQ_EN,
  input  wire logic                 B_WR,
  input  wire logic [7:0]           B_WDATA,
  input  wire timer_pkg::b_src_t    B_SRC,
  input  wire timer_pkg::b_mode_t   B_MODE,
  input  wire logic                 B_IRQ_EN,
  input  wire logic                 EXTERNAL_COUNT_CLOCK,
  output timer_pkg::unit_out_t      TIMER_A_UNIT,
  output timer_pkg::unit_out_t      TIMER_B_UNIT
);

  logic [timer_pkg::PRE_W-1:0] pre_r;
  logic [7:0]                  preset_a_r;
  logic [7:0]                  preset_b_r;
  logic [7:0]                  cnt_a_r;
  logic [7:0]                  cnt_b_r;
  logic                        ext_prev_r;
  logic                        ovf_a_r;
  logic                        ovf_b_r;
  logic                        irq_a_r;
  logic                        irq_b_r;
  logic                        tick_a;
  logic                        tick_b;
  logic                        wrap_a;
  logic                        wrap_b;
  logic                        b_counting;
  logic                        b_load;
  logic                        ext_rise;

  // True on the last cycle of each period of a power-of-two divider
  function automatic logic at_tap(input logic [timer_pkg::PRE_W-1:0] cnt,
                                  input int div);
    at_tap = ((cnt % div) == (div - 1));
  endfunction

  // One free prescaler serves every tap; B_DIV must stay a multiple of 64
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pre_r <= '0;
    end else if (pre_r == timer_pkg::PRE_W'(B_DIV - 1)) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // Inputs are synchronous, so one stage of history is enough for edges
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= EXTERNAL_COUNT_CLOCK;
    end
  end

  assign ext_rise = EXTERNAL_COUNT_CLOCK & ~ext_prev_r;

  always_comb begin
    case (B_SRC)
      timer_pkg::SRC_B_CPU:  tick_b = 1'b1;
      timer_pkg::SRC_B_DIV:  tick_b = at_tap(pre_r, B_DIV);
      timer_pkg::SRC_B_EXT:  tick_b = ext_rise;
      default:               tick_b = 1'b0;
    endcase
  end

  assign wrap_b     = tick_b && (cnt_b_r == timer_pkg::CNT_MAX);
  assign b_counting = (B_MODE == timer_pkg::MODE_COUNTER);
  assign b_load     = B_WR && b_counting;

  always_comb begin
    case (A_SRC)
      timer_pkg::SRC_A_CPU:   tick_a = 1'b1;
      timer_pkg::SRC_A_DIV8: begin
        tick_a = at_tap(pre_r, timer_pkg::DIV_A_FAST);
      end
      timer_pkg::SRC_A_DIV64: begin
        tick_a = at_tap(pre_r, timer_pkg::DIV_A_SLOW);
      end
      // A wrap lost to a counter write is no overflow, so A must not step
      timer_pkg::SRC_A_CASCADE: begin
        tick_a = wrap_b && !b_load;
      end
      default:                tick_a = 1'b0;
    endcase
  end

  assign wrap_a = tick_a && (cnt_a_r == timer_pkg::CNT_MAX);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      preset_a_r <= timer_pkg::PRESET_RST;
    end else if (A_WR) begin
      preset_a_r <= A_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      preset_b_r <= timer_pkg::PRESET_RST;
    end else if (B_WR && !b_counting) begin
      preset_b_r <= B_WDATA;
    end
  end

  // Unit A is timer only, so it always reloads on wrap
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_a_r <= timer_pkg::CNT_ZERO;
    end else if (wrap_a) begin
      cnt_a_r <= preset_a_r;
    end else if (tick_a) begin
      cnt_a_r <= cnt_a_r + 8'h01;
    end
  end

  // A counter-mode write beats a tick in the same cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt_b_r <= timer_pkg::CNT_ZERO;
    end else if (b_load) begin
      cnt_b_r <= B_WDATA;
    end else if (wrap_b && !b_counting) begin
      cnt_b_r <= preset_b_r;
    end else if (tick_b) begin
      cnt_b_r <= cnt_b_r + 8'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ovf_a_r <= 1'b0;
      ovf_b_r <= 1'b0;
    end else begin
      ovf_a_r <= wrap_a;
      ovf_b_r <= wrap_b && !b_load;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      irq_a_r <= 1'b0;
      irq_b_r <= 1'b0;
    end else begin
      irq_a_r <= wrap_a && A_IRQ_EN;
      irq_b_r <= wrap_b && !b_load && B_IRQ_EN;
    end
  end

  // Count is a plain register view: reading has no path back
  assign TIMER_A_UNIT = '{count: cnt_a_r, ovf: ovf_a_r, irq: irq_a_r};
  assign TIMER_B_UNIT = '{count: cnt_b_r, ovf: ovf_b_r,
                          irq: irq_b_r};

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  reload_a_a: assert property (
    wrap_a |=> cnt_a_r == $past(preset_a_r))
    else $error("unit A did not reload its preset");

  step_a_a: assert property (
    tick_a && !wrap_a |=> cnt_a_r == $past(cnt_a_r) + 8'h01)
    else $error("unit A did not step by one");

  reload_b_a: assert property (
    wrap_b && !b_counting && !B_WR |=> cnt_b_r == $past(preset_b_r))
    else $error("unit B timer did not reload");

  irq_gate_a: assert property (
    wrap_a |=> irq_a_r == $past(A_IRQ_EN) && ovf_a_r)
    else $error("unit A interrupt not gated by enable");

  irq_only_b_a: assert property (
    irq_b_r |-> ovf_b_r && $past(B_IRQ_EN))
    else $error("unit B interrupt without enabled overflow");

  clear_b_a: assert property (
    b_load && B_WDATA == timer_pkg::CNT_ZERO
      |=> cnt_b_r == timer_pkg::CNT_ZERO)
    else $error("counter write of zero did not clear");

  hold_b_a: assert property (
    !tick_b && !b_load |=> $stable(cnt_b_r))
    else $error("unit B count moved without a tick");

  still_b_a: assert property (
    (B_SRC == timer_pkg::SRC_B_LOW || B_SRC == timer_pkg::SRC_B_HIGH)
      && !b_load |=> $stable(cnt_b_r))
    else $error("constant level source counted");

  edge_b_a: assert property (
    b_counting && B_SRC == timer_pkg::SRC_B_EXT && !B_WR
      && EXTERNAL_COUNT_CLOCK && !ext_prev_r
      |=> cnt_b_r == $past(cnt_b_r) + 8'h01)
    else $error("external edge was not counted");

  cascade_a: assert property (
    A_SRC == timer_pkg::SRC_A_CASCADE |-> tick_a == (wrap_b && !b_load))
    else $error("cascade tick not tied to unit B overflow");

  div8_a: assert property (
    A_SRC == timer_pkg::SRC_A_DIV8 && tick_a |-> pre_r[2:0] == 3'h7)
    else $error("divide by 8 tap off phase");

  cascade_ovf_c: cover property (
    A_SRC == timer_pkg::SRC_A_CASCADE && wrap_a);
  ext_count_c: cover property (
    b_counting && B_SRC == timer_pkg::SRC_B_EXT && tick_b);
  irq_a_c: cover property (irq_a_r);
  load_tick_c: cover property (b_load && tick_b);

endmodule

// File: verification/irq_sink.sv
`timescale 1ns/1ps
// Stands in for the core's interrupt logic: it only counts pulses
module irq_sink (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq,
  output int        seen
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen <= 0;
    end else if (irq) begin
      seen <= seen + 1;
    end
  end
endmodule

// File: verification/dual_reload_timer_counter_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin \
  total_checks++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); \
  end \
end
module dual_reload_timer_counter_bench;
  logic                  clk = 0;
  logic                  rst = 1;
  logic                  a_wr = 0;
  logic                  b_wr = 0;
  logic                  a_irq_en = 0;
  logic                  b_irq_en = 0;
  logic                  ext = 0;
  logic [7:0]            a_wdata = 8'h00;
  logic [7:0]            b_wdata = 8'h00;
  logic [7:0]            p;
  timer_pkg::a_src_t     a_src = timer_pkg::SRC_A_CPU;
  timer_pkg::b_src_t     b_src = timer_pkg::SRC_B_LOW;
  timer_pkg::b_mode_t    b_mode = timer_pkg::MODE_COUNTER;
  timer_pkg::unit_out_t  ta;
  timer_pkg::unit_out_t  tb;
  logic [8:0]            q[$];
  bit                    watch = 0;
  int                    n_errors = 0;
  int                    total_checks = 0;
  int                    seen;
  int                    seen_b;
  logic [8:0]            exp_v;
  int                    k;
  int                    n;
  int                    b_inc[5] = '{64, 9, 0, 0, 0};

  always #2.5 clk = ~clk;

  // Small divider keeps the slow source inside the run length
  dual_reload_timer_counter #(.B_DIV(64)) i_dual_reload_timer_counter (
    .CLK(clk), .RST(rst), .A_WR(a_wr), .A_WDATA(a_wdata),
    .A_SRC(a_src), .A_IRQ_EN(a_irq_en), .B_WR(b_wr),
    .B_WDATA(b_wdata), .B_SRC(b_src), .B_MODE(b_mode),
    .B_IRQ_EN(b_irq_en), .EXTERNAL_COUNT_CLOCK(ext),
    .TIMER_A_UNIT(ta), .TIMER_B_UNIT(tb));
  irq_sink i_irq_sink (.clk(clk), .rst(rst), .irq(ta.irq), .seen(seen));
  // Counts only interrupts that come with their overflow flag
  irq_sink i_irq_sink_b (.clk(clk), .rst(rst), .irq(tb.irq & tb.ovf),
                         .seen(seen_b));

  always @(negedge clk) begin
    if (watch && ta.ovf === 1'b1) begin
      if (q.size() == 0) `CHK(1'b0, 1'b1)
      else begin
        // Pop once: the macro names its arguments twice
        exp_v = q.pop_front();
        `CHK({ta.count, ta.irq}, exp_v)
      end
    end
  end

  task automatic results();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr(bit b, logic [7:0] v);
    @(posedge clk);
    if (b) begin b_wr <= 1; b_wdata <= v; end
    else begin a_wr <= 1; a_wdata <= v; end
    @(posedge clk);
    a_wr <= 0;
    b_wr <= 0;
  endtask

  task automatic wait_a();
    int i;
    for (i = 0; i < 600; i++) begin
      @(negedge clk);
      if (ta.ovf === 1'b1) break;
    end
    if (i == 600) begin n_errors++; results(); end
  endtask

  // Span is a whole number of divider periods, so phase cannot matter
  task automatic rate(bit b, int span, int e);
    logic [7:0] c;
    @(negedge clk);
    c = b ? tb.count : ta.count;
    repeat (span) @(negedge clk);
    `CHK(b ? tb.count : ta.count, 8'(c + e))
  endtask

  initial begin
    k = $urandom(32'hD692A502);
    repeat (16) @(posedge clk);
    `CHK({ta, tb}, 20'h00000)
    rst <= 0;
    p = 8'($urandom_range(1, 254));
    a_irq_en <= 1;
    wr(0, p);
    q.push_back({p, 1'b1});
    watch = 1;
    wait_a();
    @(posedge clk);
    a_irq_en <= 0;
    q.push_back({p, 1'b0});
    wait_a();
    // Let the watcher take the last note before it is switched off
    @(posedge clk);
    watch = 0;
    `CHK(seen, 1)
    wr(0, 8'h00);
    for (k = 0; k < 3; k++) begin
      @(posedge clk);
      a_src <= timer_pkg::a_src_t'(k);
      rate(0, 576, 576 >> (3 * k));
    end
    @(posedge clk);
    b_mode <= timer_pkg::MODE_TIMER;
    for (k = 0; k < 5; k++) begin
      if (k == 2) continue;
      @(posedge clk);
      b_src <= timer_pkg::b_src_t'(k);
      rate(1, 576, b_inc[k]);
    end
    @(posedge clk);
    b_mode <= timer_pkg::MODE_COUNTER;
    b_src <= timer_pkg::SRC_B_EXT;
    wr(1, 8'hC3);
    wr(1, 8'h00);
    @(negedge clk);
    `CHK(tb.count, 8'h00)
    n = $urandom_range(1, 20);
    repeat (n) begin
      @(posedge clk);
      ext <= 1;
      @(posedge clk);
      ext <= 0;
    end
    repeat (4) @(negedge clk);
    `CHK(tb.count, 8'(n))
    @(negedge clk);
    `CHK(tb.count, 8'(n))
    `CHK(seen_b, 0)
    @(posedge clk);
    b_mode <= timer_pkg::MODE_TIMER;
    b_src <= timer_pkg::SRC_B_CPU;
    b_irq_en <= 1;
    a_src <= timer_pkg::SRC_A_CASCADE;
    wr(1, 8'hF0);
    repeat (300) @(posedge clk);
    rate(0, 160, 10);
    @(negedge clk);
    n = seen_b;
    repeat (160) @(negedge clk);
    `CHK(seen_b - n, 10)
    results();
  end
endmodule
